// ===== rfdrv_pkg.sv
// Package with register map, field positions, reset values and timing constants for the antenna driver control
//----------------------------------------------------------------------
// What this block does
// - Receive framing field selects reception framing
// - Enabled driver output inverted by on-invert bit
// - Disabled driver output inverted by off-invert bit
// - Continuous-wave bit gives unmodulated carrier on B
// - Field check blocks enable while field present
// - Enable bit drives modulated carrier on driver
// - Auto carrier off after last transmit bit
// - Force full ASK overrides modulation depth
// - Field wake restarts from soft power-down
// - Collision avoidance enable sets internal n
// - Initial avoidance runs, self-clears on carrier on
// - Auto-enable switches driver on after delay
// - Initial avoidance needs quiet initial delay
// - Reset values 80h and 00h
// - Registers at 14h and 15h
// - Reserved automation bit has no effect
//----------------------------------------------------------------------
package rfdrv_pkg;

  // Register indices; each register is one aligned word at four times its index
  localparam logic [5:0] RFDRV_IDX_CTRL = 6'h14;
  localparam logic [5:0] RFDRV_IDX_AUTO = 6'h15;
  localparam logic [5:0] RFDRV_IDX_RXMODE = 6'h18;
  localparam logic [5:0] RFDRV_IDX_STATUS = 6'h1C;

  // Byte addresses of the registers
  localparam logic [7:0] RFDRV_ADDR_CTRL = {RFDRV_IDX_CTRL, 2'h0};
  localparam logic [7:0] RFDRV_ADDR_AUTO = {RFDRV_IDX_AUTO, 2'h0};
  localparam logic [7:0] RFDRV_ADDR_RXMODE = {RFDRV_IDX_RXMODE, 2'h0};
  localparam logic [7:0] RFDRV_ADDR_STATUS = {RFDRV_IDX_STATUS, 2'h0};

  // Reset values
  localparam logic [7:0] RFDRV_CTRL_RST = 8'h80;
  localparam logic [7:0] RFDRV_AUTO_RST = 8'h00;
  localparam logic [7:0] RFDRV_RXMODE_RST = 8'h00;

  // Control register fields
  localparam int RFDRV_CTRL_INV_B_ON = 7;
  localparam int RFDRV_CTRL_INV_A_ON = 6;
  localparam int RFDRV_CTRL_INV_B_OFF = 5;
  localparam int RFDRV_CTRL_INV_A_OFF = 4;
  localparam int RFDRV_CTRL_B_CW = 3;
  localparam int RFDRV_CTRL_FCHECK = 2;
  localparam int RFDRV_CTRL_B_EN = 1;
  localparam int RFDRV_CTRL_A_EN = 0;

  // Automation register fields
  localparam int RFDRV_AUTO_CARRIER_OFF = 7;
  localparam int RFDRV_AUTO_FULL_ASK = 6;
  localparam int RFDRV_AUTO_WAKE = 5;
  localparam int RFDRV_AUTO_CA_EN = 3;
  localparam int RFDRV_AUTO_INIT_CA = 2;
  localparam int RFDRV_AUTO_B_AUTO = 1;
  localparam int RFDRV_AUTO_A_AUTO = 0;
  localparam logic [7:0] RFDRV_AUTO_WMASK = 8'hEF;

  // Receive framing codes
  localparam logic [1:0] RFDRV_FRM_TYPEA = 2'h0;
  localparam logic [1:0] RFDRV_FRM_ACTIVE = 2'h1;
  localparam logic [1:0] RFDRV_FRM_PASSIVE_HI = 2'h2;
  localparam logic [1:0] RFDRV_FRM_TYPEB = 2'h3;

  // Delay times in ns and derived cycle counts at 8 ns
  localparam int RFDRV_CLK_NS = 8;
  localparam int RFDRV_ACTIVE_DELAY_NS = 1000;
  localparam int RFDRV_INITIAL_DELAY_NS = 2000;
  localparam int RFDRV_ACTIVE_DELAY_CYC = (RFDRV_ACTIVE_DELAY_NS + RFDRV_CLK_NS - 1) / RFDRV_CLK_NS;
  localparam int RFDRV_INITIAL_DELAY_CYC = (RFDRV_INITIAL_DELAY_NS + RFDRV_CLK_NS - 1) / RFDRV_CLK_NS;
  localparam int RFDRV_CNT_W = 16;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rfdrv_apb_req_s;

  // Automatic switch-on sequencer state
  typedef enum logic [1:0] {
    RFDRV_IDLE,
    RFDRV_WAIT_QUIET,
    RFDRV_DELAY
  } rfdrv_auto_e;

endpackage

// ===== rfdrv_delay.sv
// Parameterised delay counter that fires when a quiet condition lasts long enough
module rfdrv_delay import rfdrv_pkg::*; #(
  parameter logic [RFDRV_CNT_W-1:0] CYCLES = 16'h0001
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic run_i,
  output logic done_o
);

  logic [RFDRV_CNT_W-1:0] cnt_q;

  // Count while running, restart whenever run drops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 16'h0000;
    end else if (!run_i) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != CYCLES) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign done_o = run_i && (cnt_q == CYCLES);

endmodule

// ===== rfdrv_top.sv
// Antenna driver control block with APB register slave
module rfdrv_top import rfdrv_pkg::*; #(
  parameter int ACTIVE_DELAY_CYC = RFDRV_ACTIVE_DELAY_CYC,
  parameter int INITIAL_DELAY_CYC = RFDRV_INITIAL_DELAY_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Analog and transmitter side
  input wire logic FIELD_DETECT_I,
  input wire logic CARRIER_I,
  input wire logic TX_DATA_I,
  input wire logic TX_LAST_BIT_I,
  input wire logic SOFT_PDOWN_I,
  // Driver pins and mode outputs
  output logic ANTENNA_DRIVER_A_O,
  output logic ANTENNA_DRIVER_B_O,
  output logic FORCE_FULL_ASK_O,
  output logic COLLISION_AVOID_O,
  output logic FIELD_WAKE_O,
  output logic [1:0] RECEIVE_FRAMING_SELECT_O
);

  //--------------------------------------------------------------------
  // Signals
  //--------------------------------------------------------------------
  rfdrv_apb_req_s req;
  logic [7:0] ctrl_q;
  logic [7:0] auto_q;
  logic [7:0] rxmode_q;
  logic field_meta_q;
  logic field_q;
  logic field_seen_q;
  rfdrv_auto_e state_q;
  logic wr_access;
  logic rd_setup;
  logic addr_ok;
  logic delay_run;
  logic delay_done;
  logic init_run;
  logic init_done;
  logic auto_fire;
  logic [7:0] ctrl_wdata;
  logic drv_a_en;
  logic drv_b_en;
  logic mod_a;
  logic mod_b;

  assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I, paddr: PADDR_I, pwdata: PWDATA_I};
  assign drv_a_en = ctrl_q[RFDRV_CTRL_A_EN];
  assign drv_b_en = ctrl_q[RFDRV_CTRL_B_EN];

  //--------------------------------------------------------------------
  // Field detector synchroniser
  //--------------------------------------------------------------------
  // Analog level is asynchronous, two flops before any use
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      field_meta_q <= 1'b0;
      field_q <= 1'b0;
    end else begin
      field_meta_q <= FIELD_DETECT_I;
      field_q <= field_meta_q;
    end
  end

  //--------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign wr_access = req.psel && req.penable && req.pwrite;
  assign rd_setup = req.psel && !req.penable && !req.pwrite;
  assign addr_ok = (req.paddr == RFDRV_ADDR_CTRL) || (req.paddr == RFDRV_ADDR_AUTO) ||
                   (req.paddr == RFDRV_ADDR_RXMODE) || (req.paddr == RFDRV_ADDR_STATUS);

  // Field check only vetoes the enable bits being set, never clearing
  always_comb begin
    ctrl_wdata = req.pwdata[7:0];
    ctrl_wdata[RFDRV_CTRL_FCHECK] = 1'b0; // Write-only, reads as zero
    if (req.pwdata[RFDRV_CTRL_FCHECK] && field_q) begin
      ctrl_wdata[RFDRV_CTRL_A_EN] = drv_a_en && req.pwdata[RFDRV_CTRL_A_EN];
      ctrl_wdata[RFDRV_CTRL_B_EN] = drv_b_en && req.pwdata[RFDRV_CTRL_B_EN];
    end
  end

  //--------------------------------------------------------------------
  // Ready, error and read data
  //--------------------------------------------------------------------
  // Ready rises with the setup cycle so the access phase ends at once
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= req.psel && !req.penable;
      PSLVERR_O <= req.psel && !req.penable && !addr_ok;
    end
  end

  // Read data captured in setup, valid during access
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (req.paddr)
        RFDRV_ADDR_CTRL: PRDATA_O <= {24'h00_0000, ctrl_q};
        RFDRV_ADDR_AUTO: PRDATA_O <= {24'h00_0000, auto_q};
        RFDRV_ADDR_RXMODE: PRDATA_O <= {24'h00_0000, rxmode_q};
        RFDRV_ADDR_STATUS: PRDATA_O <= {28'h000_0000, state_q, field_q, SOFT_PDOWN_I};
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end else begin
      PRDATA_O <= 32'h0000_0000;
    end
  end

  //--------------------------------------------------------------------
  // Automatic switch-on sequencer
  //--------------------------------------------------------------------
  // Initial avoidance waits for a quiet window, else waits for field then off
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= RFDRV_IDLE;
    end else begin
      unique case (state_q)
        RFDRV_IDLE: begin
          if (auto_q[RFDRV_AUTO_A_AUTO] || auto_q[RFDRV_AUTO_B_AUTO]) begin
            state_q <= RFDRV_WAIT_QUIET;
          end
        end
        RFDRV_WAIT_QUIET: begin
          if (!(auto_q[RFDRV_AUTO_A_AUTO] || auto_q[RFDRV_AUTO_B_AUTO])) begin
            state_q <= RFDRV_IDLE;
          end else if (!field_q && (field_seen_q || auto_q[RFDRV_AUTO_INIT_CA])) begin
            state_q <= RFDRV_DELAY;
          end
        end
        RFDRV_DELAY: begin
          if (field_q || !(auto_q[RFDRV_AUTO_A_AUTO] || auto_q[RFDRV_AUTO_B_AUTO])) begin
            state_q <= RFDRV_WAIT_QUIET;
          end else if (auto_fire) begin
            state_q <= RFDRV_IDLE;
          end
        end
      endcase
    end
  end

  // Remembers that an external field was present before it dropped
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      field_seen_q <= 1'b0;
    end else if (field_q) begin
      field_seen_q <= 1'b1;
    end else if (state_q == RFDRV_DELAY) begin
      field_seen_q <= 1'b0;
    end
  end

  assign delay_run = (state_q == RFDRV_DELAY) && !field_q && !auto_q[RFDRV_AUTO_INIT_CA];
  assign init_run = (state_q == RFDRV_DELAY) && !field_q && auto_q[RFDRV_AUTO_INIT_CA];
  assign auto_fire = delay_done || init_done;

  // Active delay after the external field goes away
  rfdrv_delay #(
    .CYCLES(RFDRV_CNT_W'(ACTIVE_DELAY_CYC))
  ) u_active_delay (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .run_i(delay_run),
    .done_o(delay_done)
  );

  // Initial delay, any field during it restarts the wait
  rfdrv_delay #(
    .CYCLES(RFDRV_CNT_W'(INITIAL_DELAY_CYC))
  ) u_initial_delay (
    .clk_i(CLK_SYS_I),
    .nrst_i(NRST_I),
    .run_i(init_run),
    .done_o(init_done)
  );

  //--------------------------------------------------------------------
  // Control register
  //--------------------------------------------------------------------
  // Hardware switch-off beats hardware switch-on beats software write
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_q <= RFDRV_CTRL_RST;
    end else begin
      if (wr_access && req.paddr == RFDRV_ADDR_CTRL) begin
        ctrl_q <= ctrl_wdata;
      end
      if (auto_fire) begin
        if (auto_q[RFDRV_AUTO_A_AUTO]) begin
          ctrl_q[RFDRV_CTRL_A_EN] <= 1'b1;
        end
        if (auto_q[RFDRV_AUTO_B_AUTO]) begin
          ctrl_q[RFDRV_CTRL_B_EN] <= 1'b1;
        end
      end
      if (auto_q[RFDRV_AUTO_CARRIER_OFF] && TX_LAST_BIT_I) begin
        ctrl_q[RFDRV_CTRL_A_EN] <= 1'b0;
        ctrl_q[RFDRV_CTRL_B_EN] <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Automation and receive mode registers
  //--------------------------------------------------------------------
  // Reserved bit 4 is masked so it stays zero; self-clear wins over write
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      auto_q <= RFDRV_AUTO_RST;
    end else begin
      if (wr_access && req.paddr == RFDRV_ADDR_AUTO) begin
        auto_q <= req.pwdata[7:0] & RFDRV_AUTO_WMASK;
      end
      if (init_done) begin
        auto_q[RFDRV_AUTO_INIT_CA] <= 1'b0;
      end
    end
  end

  // Receive framing held for the receiver
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rxmode_q <= RFDRV_RXMODE_RST;
    end else if (wr_access && req.paddr == RFDRV_ADDR_RXMODE) begin
      rxmode_q <= req.pwdata[7:0];
    end
  end

  //--------------------------------------------------------------------
  // Driver output path
  //--------------------------------------------------------------------
  // Disabled driver rests low before the off-invert is applied
  assign mod_a = drv_a_en && CARRIER_I && TX_DATA_I;
  assign mod_b = drv_b_en && CARRIER_I && (ctrl_q[RFDRV_CTRL_B_CW] || TX_DATA_I);

  // Outputs registered, so the pins lag the carrier by one cycle
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ANTENNA_DRIVER_A_O <= 1'b0;
      ANTENNA_DRIVER_B_O <= 1'b0;
    end else begin
      ANTENNA_DRIVER_A_O <= mod_a ^ (drv_a_en ? ctrl_q[RFDRV_CTRL_INV_A_ON]
                                              : ctrl_q[RFDRV_CTRL_INV_A_OFF]);
      ANTENNA_DRIVER_B_O <= mod_b ^ (drv_b_en ? ctrl_q[RFDRV_CTRL_INV_B_ON]
                                              : ctrl_q[RFDRV_CTRL_INV_B_OFF]);
    end
  end

  //--------------------------------------------------------------------
  // Mode outputs
  //--------------------------------------------------------------------
  // Wake is a level while powered down and a field is present
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FORCE_FULL_ASK_O <= 1'b0;
      COLLISION_AVOID_O <= 1'b0;
      FIELD_WAKE_O <= 1'b0;
      RECEIVE_FRAMING_SELECT_O <= RFDRV_FRM_TYPEA;
    end else begin
      FORCE_FULL_ASK_O <= auto_q[RFDRV_AUTO_FULL_ASK];
      COLLISION_AVOID_O <= auto_q[RFDRV_AUTO_CA_EN];
      FIELD_WAKE_O <= auto_q[RFDRV_AUTO_WAKE] && SOFT_PDOWN_I && field_q;
      RECEIVE_FRAMING_SELECT_O <= rxmode_q[1:0];
    end
  end

endmodule

// ===== rfdrv_field_model.sv
// Behavioural model of the external RF field as seen by the level detector
//----------------------------------------------------------------------
// Field model
//----------------------------------------------------------------------
module rfdrv_field_model (
  // Clock
  input wire logic clk_i,
  // Field request from the bench
  input wire logic field_req_i,
  // Detector level
  output logic field_o
);
  // Level changes right after an edge of the same clock that the block samples with
  always_ff @(posedge clk_i) begin
    field_o <= field_req_i;
  end
endmodule

// ===== rfdrv_chk.sv
// Checker of register bus answers and mode outputs of the antenna driver block
module rfdrv_chk import rfdrv_pkg::*; #(
  parameter int ACTIVE_DELAY_CYC = RFDRV_ACTIVE_DELAY_CYC,
  parameter int INITIAL_DELAY_CYC = RFDRV_INITIAL_DELAY_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  // APB
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  // Field and modes
  input wire logic FIELD_DETECT_I,
  input wire logic SOFT_PDOWN_I,
  input wire logic FORCE_FULL_ASK_O,
  input wire logic COLLISION_AVOID_O,
  input wire logic FIELD_WAKE_O,
  input wire logic [1:0] RECEIVE_FRAMING_SELECT_O
);
  //----------------------------------------------------------------------
  // Helpers and properties
  //----------------------------------------------------------------------
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);
  logic acc;
  logic rd;
  logic mapped;
  // Access phase decode, reads and writes, plus its read subset
  assign acc = PSEL_I && PENABLE_I;
  assign rd = acc && !PWRITE_I;
  assign mapped = PADDR_I inside {RFDRV_ADDR_CTRL, RFDRV_ADDR_AUTO, RFDRV_ADDR_RXMODE, RFDRV_ADDR_STATUS};
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("ready missing");
  a_ready_only_access: assert property (!acc |-> !PREADY_O) else $error("stray ready");
  a_err_unmapped: assert property (acc && !mapped |-> PSLVERR_O) else $error("no error");
  a_err_mapped_ok: assert property (acc && mapped |-> !PSLVERR_O) else $error("false error");
  a_rdata_idle_zero: assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000) else $error("rdata idle");
  a_framing_read: assert property (rd && PADDR_I == RFDRV_ADDR_RXMODE |-> PRDATA_O[1:0] == RECEIVE_FRAMING_SELECT_O)
    else $error("framing mismatch");
  a_auto_modes: assert property (rd && PADDR_I == RFDRV_ADDR_AUTO |->
    PRDATA_O[6] == FORCE_FULL_ASK_O && PRDATA_O[3] == COLLISION_AVOID_O && !PRDATA_O[4])
    else $error("mode bits");
  a_check_bit_zero: assert property (rd && PADDR_I == RFDRV_ADDR_CTRL |-> !PRDATA_O[2]) else $error("check bit");
  a_wake_pdown: assert property (!$past(SOFT_PDOWN_I) |-> !FIELD_WAKE_O) else $error("wake awake");
  a_wake_field: assert property (!FIELD_DETECT_I [*4] |=> !FIELD_WAKE_O) else $error("wake no field");
  // Main scenarios reached
  c_slverr: cover property (PSLVERR_O);
  c_wake: cover property (FIELD_WAKE_O);
  c_modes: cover property (FORCE_FULL_ASK_O && COLLISION_AVOID_O);
endmodule
bind rfdrv_top rfdrv_chk #(.ACTIVE_DELAY_CYC(ACTIVE_DELAY_CYC), .INITIAL_DELAY_CYC(INITIAL_DELAY_CYC)) rfdrv_chk_inst (
  .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .FIELD_DETECT_I(FIELD_DETECT_I), .SOFT_PDOWN_I(SOFT_PDOWN_I), .FORCE_FULL_ASK_O(FORCE_FULL_ASK_O),
  .COLLISION_AVOID_O(COLLISION_AVOID_O), .FIELD_WAKE_O(FIELD_WAKE_O),
  .RECEIVE_FRAMING_SELECT_O(RECEIVE_FRAMING_SELECT_O));

// ===== test_rf_antenna_driver_control.sv
// Self-checking testbench of the antenna driver control block
module test_rf_antenna_driver_control import rfdrv_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  //----------------------------------------------------------------------
  // Stimulus, design and field model
  //----------------------------------------------------------------------
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, carrier = 0, txd = 0, last = 0, pdown = 0, freq = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, fld, drv_a, drv_b, ask, ca, wake;
  logic [1:0] frm;
  int err_total = 0;
  int n_compared = 0;
  // Clock of 8 ns
  always #4 clk = ~clk;
  // Short delays keep the automatic switch-on runs brief
  rfdrv_top #(.ACTIVE_DELAY_CYC(4), .INITIAL_DELAY_CYC(4)) rfdrv_top_inst (.CLK_SYS_I(clk), .NRST_I(nrst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .FIELD_DETECT_I(fld), .CARRIER_I(carrier),
    .TX_DATA_I(txd), .TX_LAST_BIT_I(last), .SOFT_PDOWN_I(pdown), .ANTENNA_DRIVER_A_O(drv_a),
    .ANTENNA_DRIVER_B_O(drv_b), .FORCE_FULL_ASK_O(ask), .COLLISION_AVOID_O(ca), .FIELD_WAKE_O(wake),
    .RECEIVE_FRAMING_SELECT_O(frm));
  rfdrv_field_model rfdrv_field_model_inst (.clk_i(clk), .field_req_i(freq), .field_o(fld));
  //----------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; ready and answer taken at the rising edge, then released
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        conclude();
      end
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h00_0000, d}, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic eexp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, {24'h00_0000, exp});
    chk(32'(e), 32'(eexp));
  endtask
  // Reads until the masked field settles, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 60; i++) begin
      apb(1'b0, a, 32'h0000_0000, q, e);
      if ((q[7:0] & m) === exp) return;
    end
    err_total++;
    conclude();
  endtask
  // Carrier high; pins follow one cycle after the inputs
  task automatic drv(input logic [7:0] c, input logic t, input logic ea, input logic eb);
    wr(RFDRV_ADDR_CTRL, c);
    txd <= t;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(drv_a), 32'(ea));
    chk(32'(drv_b), 32'(eb));
  endtask
  //----------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------
  task automatic t_regs();
    rd_chk(RFDRV_ADDR_CTRL, 8'h80, 1'b0);
    rd_chk(RFDRV_ADDR_AUTO, 8'h00, 1'b0);
    wr(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00, 1'b1);
    wr(RFDRV_ADDR_AUTO, 8'hF0);
    rd_chk(RFDRV_ADDR_AUTO, 8'hE0, 1'b0);
    wr(RFDRV_ADDR_AUTO, 8'h00);
  endtask
  task automatic t_framing();
    for (int i = 0; i < 4; i++) begin
      wr(RFDRV_ADDR_RXMODE, 8'(i));
      @(posedge clk);
      @(negedge clk);
      chk(32'(frm), 32'(i));
    end
  endtask
  task automatic t_drivers();
    carrier <= 1'b1;
    drv(8'h03, 1'b1, 1'b1, 1'b1);
    drv(8'h03, 1'b0, 1'b0, 1'b0);
    drv(8'h0B, 1'b0, 1'b0, 1'b1);
    drv(8'hC3, 1'b1, 1'b0, 1'b0);
    drv(8'hC3, 1'b0, 1'b1, 1'b1);
    drv(8'h30, 1'b1, 1'b1, 1'b1);
    drv(8'h00, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_fcheck_autooff();
    freq <= 1'b1;
    repeat (5) @(posedge clk);
    wr(RFDRV_ADDR_CTRL, 8'h07);
    rd_chk(RFDRV_ADDR_CTRL, 8'h00, 1'b0);
    freq <= 1'b0;
    repeat (5) @(posedge clk);
    wr(RFDRV_ADDR_CTRL, 8'h07);
    rd_chk(RFDRV_ADDR_CTRL, 8'h03, 1'b0);
    wr(RFDRV_ADDR_AUTO, 8'h80);
    last <= 1'b1;
    @(posedge clk);
    last <= 1'b0;
    rd_chk(RFDRV_ADDR_CTRL, 8'h00, 1'b0);
  endtask
  task automatic t_auto_on();
    wr(RFDRV_ADDR_AUTO, 8'h01);
    freq <= 1'b1;
    repeat (6) @(posedge clk);
    freq <= 1'b0;
    poll(RFDRV_ADDR_CTRL, 8'h03, 8'h01);
    wr(RFDRV_ADDR_CTRL, 8'h00);
    freq <= 1'b1;
    wr(RFDRV_ADDR_AUTO, 8'h06);
    repeat (20) @(posedge clk);
    rd_chk(RFDRV_ADDR_AUTO, 8'h06, 1'b0);
    freq <= 1'b0;
    poll(RFDRV_ADDR_AUTO, 8'hFF, 8'h02);
    rd_chk(RFDRV_ADDR_CTRL, 8'h02, 1'b0);
  endtask
  task automatic t_modes();
    wr(RFDRV_ADDR_AUTO, 8'h68);
    pdown <= 1'b1;
    freq <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(32'(ask), 32'h0000_0001);
    chk(32'(ca), 32'h0000_0001);
    chk(32'(wake), 32'h0000_0001);
  endtask
  // Mid-run reset: driver B was on, must be low two cycles into reset; control and automation registers return to reset values
  task automatic t_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(drv_b), 32'h0000_0000);
    @(posedge clk);
    nrst <= 1'b1;
    rd_chk(RFDRV_ADDR_CTRL, 8'h80, 1'b0);
    rd_chk(RFDRV_ADDR_AUTO, 8'h00, 1'b0);
  endtask
  // Reset for 12 cycles, then the scenarios in turn
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_framing();
    t_drivers();
    t_fcheck_autooff();
    t_auto_on();
    t_modes();
    t_reset();
    conclude();
  end
endmodule
